// ### include/tdo_pkg.sv
// constants, field layouts and carrier types of the touch detect output logic
// assumes a single 50 MHz clock; the cycle counts below are derived from it
package tdo_pkg;

  // clock
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;

  // millisecond time base for the on-duration timer
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYCLES   = TICK_US * CLK_PER_US;

  // max on-duration settings
  localparam int unsigned TMO_SHORT_S   = 10;
  localparam int unsigned TMO_LONG_S    = 60;
  localparam int unsigned TMO_SHORT_MS  = TMO_SHORT_S * 1000;
  localparam int unsigned TMO_LONG_MS   = TMO_LONG_S * 1000;

  // health pulse: output released to high impedance after each burst
  localparam int unsigned HEALTH_US     = 300;
  localparam int unsigned HEALTH_CYCLES = HEALTH_US * CLK_PER_US;

  // detection
  localparam logic [4:0]  THR_HIGH_GAIN = 5'h06;
  localparam logic [4:0]  THR_LOW_GAIN  = 5'h0C;
  localparam int unsigned HYST_PCT      = 17;
  localparam logic [1:0]  INTEG_LIMIT   = 2'h3;

  // register map, byte addresses on the Avalon-MM slave
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam logic [3:0]  REG_REF       = 4'h8;
  localparam logic [3:0]  REG_SAMPLE    = 4'hC;

  // control register: drift divider in the low byte
  localparam int unsigned CTRL_DRIFT_LSB = 0;
  localparam logic [7:0]  CTRL_DRIFT_RST = 8'h10;

  // status register field positions
  localparam int unsigned ST_DETECT     = 0;
  localparam int unsigned ST_OUT        = 1;
  localparam int unsigned ST_OE         = 2;
  localparam int unsigned ST_TOGGLE     = 3;
  localparam int unsigned ST_TMO_LSB    = 4;
  localparam int unsigned ST_GAIN       = 6;
  localparam int unsigned ST_INTEG_LSB  = 8;
  localparam int unsigned ST_PHASE_LSB  = 12;

  localparam logic [15:0] REF_RST       = 16'h0000;

  typedef enum logic [1:0] {TMO_SHORT, TMO_LONG, TMO_NONE} tdo_tmo_e;
  typedef enum logic [1:0] {PH_STRAP, PH_CAL, PH_RUN} tdo_phase_e;

  // option set captured once after power-up
  typedef struct packed {
    logic     toggle_mode;
    tdo_tmo_e tmo;
    logic     gain_high;
  } tdo_cfg_s;

  // Avalon-MM request as seen by the slave
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } tdo_avs_req_s;

  // whole state of the top module
  typedef struct packed {
    tdo_phase_e  phase;
    tdo_cfg_s    cfg;
    logic [15:0] ref_lvl;
    logic [15:0] last;
    logic [1:0]  integ;
    logic        detect;
    logic        toggle;
    logic [7:0]  drift_div;
    logic [7:0]  drift_cnt;
    logic [15:0] health_cnt;
    logic        out;
    logic        oe;
    logic        wait_req;
    logic [31:0] rdata;
  } tdo_state_s;

endpackage

// ### verilog/tdo_ontimer.sv
// on-duration timer: counts milliseconds while a detection stands
// assumes i_run drops within a few cycles of o_expired
`timescale 1ns/1ns
module tdo_ontimer #(
  parameter int unsigned TICK_CYCLES = tdo_pkg::TICK_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_run,
  input  wire logic [15:0] i_limit_ms,
  output logic             o_expired
);

  typedef struct packed {
    logic [15:0] div;
    logic [15:0] ms;
    logic        expired;
  } tdo_tmr_s;

  tdo_tmr_s q;
  tdo_tmr_s d;

  always_comb begin
    d         = q;
    d.expired = 1'b0;
    if (!i_run) begin
      // restart from zero so each detection gets the full interval
      d.div = 16'h0000;
      d.ms  = 16'h0000;
    end else if (q.div == 16'(TICK_CYCLES - 1)) begin
      d.div = 16'h0000;
      if (q.ms == i_limit_ms - 16'h0001) begin
        d.expired = 1'b1;
        d.ms      = 16'h0000;
      end else begin
        d.ms = q.ms + 16'h0001;
      end
    end else begin
      d.div = q.div + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_expired = q.expired;

endmodule // tdo_ontimer

// ### verilog/tdo_touch_out.sv
// touch detect output logic: threshold, integrator, on-duration, output pin
// assumes one burst measurement per I_SAMPLE_VALID pulse, straps tied firmly
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ns
module tdo_touch_out #(
  parameter int unsigned TICK_CYCLES   = tdo_pkg::TICK_CYCLES,
  parameter int unsigned TMO_SHORT_MS  = tdo_pkg::TMO_SHORT_MS,
  parameter int unsigned TMO_LONG_MS   = tdo_pkg::TMO_LONG_MS,
  parameter int unsigned HEALTH_CYCLES = tdo_pkg::HEALTH_CYCLES
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  input  wire logic        I_SAMPLE_VALID,
  input  wire logic [15:0] I_SAMPLE,
  input  wire logic        I_OPTION_STRAP_A,
  input  wire logic        I_OPTION_STRAP_B,
  input  wire logic        I_GAIN_STRAP,
  input  wire logic [3:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0]      O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  output logic             O_OUT,
  output logic             O_OUT_OE
);

  tdo_pkg::tdo_state_s   q;
  tdo_pkg::tdo_state_s   d;
  tdo_pkg::tdo_avs_req_s req;
  logic                  expired;
  logic [15:0]           limit_ms;
  logic                  run_tmr;

  // strap pair decode
  function automatic tdo_pkg::tdo_cfg_s decode_straps(input logic a,
                                                      input logic b,
                                                      input logic g);
    tdo_pkg::tdo_cfg_s c;
    c.gain_high   = g;
    c.toggle_mode = 1'b0;
    c.tmo         = tdo_pkg::TMO_SHORT;
    unique case ({a, b})
      2'b11: c.tmo = tdo_pkg::TMO_SHORT;
      2'b10: c.tmo = tdo_pkg::TMO_LONG;
      2'b00: begin
        c.toggle_mode = 1'b1;
        c.tmo         = tdo_pkg::TMO_SHORT;
      end
      2'b01: c.tmo = tdo_pkg::TMO_NONE;
    endcase
    return c;
  endfunction

  // gain strap picks the offset above the reference
  function automatic logic [4:0] thr_of(input logic gain_high);
    return gain_high ? tdo_pkg::THR_HIGH_GAIN : tdo_pkg::THR_LOW_GAIN;
  endfunction

  // hysteresis in whole counts, truncated
  function automatic logic [4:0] hyst_of(input logic [4:0] thr);
    int unsigned h;
    h = (int'(thr) * tdo_pkg::HYST_PCT) / 100;
    return 5'(h);
  endfunction

  // one slew-limited step of the reference toward the raw signal
  function automatic logic [15:0] track_step(input logic [15:0] ref_now,
                                             input logic [15:0] raw);
    logic [15:0] r;
    r = ref_now;
    if (raw > ref_now) begin
      r = ref_now + 16'h0001;
    end else if (raw < ref_now) begin
      r = ref_now - 16'h0001;
    end
    return r;
  endfunction

  // signed distance above the reference against set and release levels
  function automatic logic [1:0] judge(input logic [15:0] raw,
                                       input logic [15:0] ref_now,
                                       input logic [4:0]  thr,
                                       input logic [4:0]  rel);
    logic signed [16:0] delta;
    logic               over;
    logic               hold;
    delta = signed'({1'b0, raw}) - signed'({1'b0, ref_now});
    over  = delta >= signed'({12'h000, thr});
    hold  = delta >= signed'({12'h000, rel});
    return {over, hold};
  endfunction

  // status word as software reads it
  function automatic logic [31:0] status_word(input tdo_pkg::tdo_state_s s);
    logic [31:0] w;
    w                             = 32'h00000000;
    w[tdo_pkg::ST_DETECT]         = s.detect;
    w[tdo_pkg::ST_OUT]            = s.out;
    w[tdo_pkg::ST_OE]             = s.oe;
    w[tdo_pkg::ST_TOGGLE]         = s.cfg.toggle_mode;
    w[tdo_pkg::ST_TMO_LSB +: 2]   = s.cfg.tmo;
    w[tdo_pkg::ST_GAIN]           = s.cfg.gain_high;
    w[tdo_pkg::ST_INTEG_LSB +: 2] = s.integ;
    w[tdo_pkg::ST_PHASE_LSB +: 2] = s.phase;
    return w;
  endfunction

  // read mux; unmapped offsets read as zero
  function automatic logic [31:0] read_word(input tdo_pkg::tdo_state_s s,
                                            input logic [3:0]          addr);
    logic [31:0] w;
    w = 32'h00000000;
    unique case (addr)
      tdo_pkg::REG_CTRL:   w = {24'h000000, s.drift_div};
      tdo_pkg::REG_STATUS: w = status_word(s);
      tdo_pkg::REG_REF:    w = {16'h0000, s.ref_lvl};
      tdo_pkg::REG_SAMPLE: w = {16'h0000, s.last};
      default:             w = 32'h00000000;
    endcase
    return w;
  endfunction

  // only the control register takes writes; the rest are read-only
  function automatic logic [7:0] ctrl_next(input logic [7:0]            now,
                                           input tdo_pkg::tdo_avs_req_s r,
                                           input logic                  answer);
    logic [7:0] v;
    v = now;
    if (r.write && answer && r.address == tdo_pkg::REG_CTRL) begin
      v = r.writedata[tdo_pkg::CTRL_DRIFT_LSB +: 8];
    end
    return v;
  endfunction

  assign req.address   = I_AVS_ADDRESS;
  assign req.read      = I_AVS_READ;
  assign req.write     = I_AVS_WRITE;
  assign req.writedata = I_AVS_WRITEDATA;

  // timer only runs when a finite limit applies
  assign run_tmr  = q.detect && (q.phase == tdo_pkg::PH_RUN) &&
                    (q.cfg.tmo != tdo_pkg::TMO_NONE);
  assign limit_ms = (q.cfg.tmo == tdo_pkg::TMO_LONG) ? 16'(TMO_LONG_MS)
                                                     : 16'(TMO_SHORT_MS);

  tdo_ontimer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_ontimer (
    .i_clk      (I_CLOCK),
    .i_rst      (I_RST),
    .i_run      (run_tmr),
    .i_limit_ms (limit_ms),
    .o_expired  (expired)
  );

  always_comb begin
    logic [4:0] thr;
    logic [4:0] rel;
    logic       over;
    logic       hold;
    logic       was_det;
    logic       bus_take;
    // offsets only; the reference is added inside judge
    thr      = thr_of(q.cfg.gain_high);
    rel      = thr - hyst_of(thr);
    over     = 1'b0;
    hold     = 1'b0;
    was_det  = q.detect;
    bus_take = (req.read || req.write) && q.wait_req;
    d        = q;

    unique case (q.phase)
      tdo_pkg::PH_STRAP: begin
        // one clocked capture after reset release, never again
        d.cfg   = decode_straps(I_OPTION_STRAP_A, I_OPTION_STRAP_B, I_GAIN_STRAP);
        d.phase = tdo_pkg::PH_CAL;
      end
      tdo_pkg::PH_CAL: begin
        if (I_SAMPLE_VALID) begin
          // full recalibration: reference restarts at the present signal
          d.ref_lvl   = I_SAMPLE;
          d.last      = I_SAMPLE;
          d.integ     = 2'h0;
          d.detect    = 1'b0;
          d.drift_cnt = 8'h00;
          d.phase     = tdo_pkg::PH_RUN;
        end
      end
      tdo_pkg::PH_RUN: begin
        if (expired) begin
          // stuck detection: drop it and rebuild the reference
          d.detect = 1'b0;
          d.integ  = 2'h0;
          d.phase  = tdo_pkg::PH_CAL;
        end else if (I_SAMPLE_VALID) begin
          d.last = I_SAMPLE;
          // threshold and release ride on the reference, never absolute
          {over, hold} = judge(I_SAMPLE, q.ref_lvl, thr, rel);
          if (q.detect) begin
            if (!hold) begin
              d.detect = 1'b0;
              d.integ  = 2'h0;
            end
          end else if (over) begin
            if (q.integ == tdo_pkg::INTEG_LIMIT - 2'h1) begin
              d.detect = 1'b1;
              d.integ  = tdo_pkg::INTEG_LIMIT;
            end else begin
              d.integ = q.integ + 2'h1;
            end
          end else begin
            d.integ = 2'h0;
          end
          // slow slew-limited tracking, never while detecting
          if (!q.detect) begin
            if (q.drift_cnt >= q.drift_div) begin
              d.drift_cnt = 8'h00;
              d.ref_lvl = track_step(q.ref_lvl, I_SAMPLE);
            end else begin
              d.drift_cnt = q.drift_cnt + 8'h01;
            end
          end
        end
      end
      default: d.phase = tdo_pkg::PH_CAL;
    endcase

    // output follows the integrator's decision of this burst
    if (d.detect && !was_det) begin
      d.toggle = ~q.toggle;
    end
    if (q.cfg.toggle_mode) begin
      d.out = ~d.toggle;
    end else begin
      d.out = ~d.detect;
    end

    // health pulse after every burst except in the strap capture cycle, whatever the output state
    if (I_SAMPLE_VALID && q.phase != tdo_pkg::PH_STRAP) begin
      d.health_cnt = 16'(HEALTH_CYCLES);
    end else if (q.health_cnt != 16'h0000) begin
      d.health_cnt = q.health_cnt - 16'h0001;
    end
    d.oe = (d.health_cnt == 16'h0000);
    // level frozen while released; a late change shows once driven again
    if (!q.oe && !d.oe) begin
      d.out = q.out;
    end

    // Avalon slave: one wait cycle, answer on the second
    d.wait_req = !bus_take;
    // read data stays until the next read answer
    if (bus_take && req.read) begin
      d.rdata = read_word(q, req.address);
    end
    // write lands on the edge where waitrequest is seen low
    d.drift_div = ctrl_next(q.drift_div, req, !q.wait_req);
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      // pin driven high and bus busy from the first instant of reset
      q            <= '0;
      q.phase      <= tdo_pkg::PH_STRAP;
      q.cfg        <= '0;
      q.ref_lvl    <= tdo_pkg::REF_RST;
      q.drift_div  <= tdo_pkg::CTRL_DRIFT_RST;
      q.out        <= 1'b1;
      q.oe         <= 1'b1;
      q.wait_req   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // every output is a flop of q, no logic after the register
  assign O_AVS_READDATA    = q.rdata;
  assign O_AVS_WAITREQUEST = q.wait_req;
  assign O_OUT             = q.out;
  assign O_OUT_OE          = q.oe;

endmodule // tdo_touch_out

// ### bench/tdo_touch_out_props.sv
// checker on the top ports of the touch detect output logic
// assumes one clock and an async active high reset; bound below
`timescale 1ns/1ns
module tdo_touch_out_props #(
  parameter int unsigned HEALTH_CYCLES = tdo_pkg::HEALTH_CYCLES
) (
  input wire logic        I_CLOCK,
  input wire logic        I_RST,
  input wire logic        I_SAMPLE_VALID,
  input wire logic [3:0]  I_AVS_ADDRESS,
  input wire logic        I_AVS_READ,
  input wire logic        I_AVS_WRITE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic        O_AVS_WAITREQUEST,
  input wire logic        O_OUT,
  input wire logic        O_OUT_OE
);
  // cycles the pin has been released; a counter since repetition stops at 8
  logic [15:0] hz_cnt_q;
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) hz_cnt_q <= 16'h0000;
    else hz_cnt_q <= O_OUT_OE ? 16'h0000 : hz_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  a_bus_answer: assert property (
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("bus request not answered next cycle");
  a_bus_single: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("bus answer longer than one cycle");
  a_bus_idle: assert property (
    !I_AVS_READ && !I_AVS_WRITE && O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("bus answer without request");
  a_unmapped_zero: assert property (
    I_AVS_READ && O_AVS_WAITREQUEST && I_AVS_ADDRESS[1:0] != 2'h0 |=> O_AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_health_start: assert property (I_SAMPLE_VALID |-> ##[1:2] !O_OUT_OE)
    else $error("pin not released after burst");
  a_health_len: assert property ($rose(O_OUT_OE) |-> hz_cnt_q == HEALTH_CYCLES)
    else $error("release length wrong");
  a_health_max: assert property (hz_cnt_q <= HEALTH_CYCLES)
    else $error("release too long");
  a_out_burst: assert property (
    $fell(O_OUT) |-> $past(I_SAMPLE_VALID) || $past(I_SAMPLE_VALID, 2))
    else $error("output active without burst");
  a_out_hiz_kept: assert property (!O_OUT_OE && !$past(O_OUT_OE) |-> $stable(O_OUT))
    else $error("output level moved while released");
endmodule // tdo_touch_out_props

bind tdo_touch_out tdo_touch_out_props #(.HEALTH_CYCLES(HEALTH_CYCLES)) tdo_touch_out_props_i (
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_SAMPLE_VALID(I_SAMPLE_VALID),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .O_OUT(O_OUT), .O_OUT_OE(O_OUT_OE));

// ### bench/tdo_load_model.sv
// load at the output pin: pull-down resistor, nothing else drives it
// assumes the sensor releases the pin whenever its enable is low
`timescale 1ns/1ns
module tdo_load_model (
  input  wire logic i_out,
  input  wire logic i_out_oe,
  output logic      o_pin
);
  // pull-down wins while released, so health pulses show as lows
  assign o_pin = i_out_oe ? i_out : 1'b0;
endmodule // tdo_load_model

// ### bench/tdo_touch_out_tb.sv
// self-checking bench for tdo_touch_out with a pull-down load
// assumes shortened counts: 10 cycle tick, 5 and 8 tick timeouts
`timescale 1ns/1ns
module tdo_touch_out_tb;
  localparam logic [15:0] REF = 16'h0100;
  logic        clk, rst, sv, sa, sb, sg, rd, wr, wq, out, oe, pin;
  logic [15:0] smp, thr, hy;
  logic [3:0]  adr;
  logic [31:0] wd, rdq, got;
  int          err_total, n_checks, i;
  // straps a, b, gain in bits 6:4, expected status bits 6:3 below
  logic [6:0]  tbl [4] = '{7'h78, 7'h42, 7'h19, 7'h24};

  tdo_touch_out #(.TICK_CYCLES(10), .TMO_SHORT_MS(5), .TMO_LONG_MS(8),
    .HEALTH_CYCLES(20)) tdo_touch_out_i (
    .I_CLOCK(clk), .I_RST(rst), .I_SAMPLE_VALID(sv), .I_SAMPLE(smp),
    .I_OPTION_STRAP_A(sa), .I_OPTION_STRAP_B(sb), .I_GAIN_STRAP(sg),
    .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
    .O_AVS_READDATA(rdq), .O_AVS_WAITREQUEST(wq), .O_OUT(out), .O_OUT_OE(oe));
  tdo_load_model tdo_load_model_i (.i_out(out), .i_out_oe(oe), .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic e);
    chk({31'h0, pin}, {31'h0, e});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (n >= 50) err_total++;
    got = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // bursts spaced past the 20 cycle release
  task automatic burst(input logic [15:0] v);
    @(posedge clk);
    sv <= 1'b1;
    smp <= v;
    @(posedge clk);
    sv <= 1'b0;
    repeat (24) @(posedge clk);
  endtask
  // straps set firmly, then supply cycled; slowest drift, then calibrate
  task automatic power_up(input int k);
    rst <= 1'b1;
    {sa, sb, sg} <= tbl[k][6:4];
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 4'h0, 32'h0000_00FF);
    burst(REF);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial begin
    {rst, sv, sa, sb, sg, rd, wr} = 7'h40;
    {smp, adr, wd} = '0;
    err_total = 0;
    n_checks = 0;
    for (i = 0; i < 4; i++) begin
      power_up(i);
      thr = tbl[i][4] ? 16'h0006 : 16'h000C;
      hy = (thr * 16'h0011) / 16'h0064;
      {sa, sb, sg} <= ~tbl[i][6:4];
      bus(1'b0, 4'h4, 32'h0);
      chk((got >> 3) & 32'hF, {28'h0, tbl[i][3:0]});
      @(posedge clk);
      sv <= 1'b1;
      smp <= REF + thr;
      @(posedge clk);
      sv <= 1'b0;
      repeat (2) @(posedge clk);
      chk_pin(1'b0);
      repeat (22) @(posedge clk);
      burst(REF + thr);
      burst(REF + thr - 16'h0001);
      burst(REF + thr);
      burst(REF + thr);
      chk_pin(1'b1);
      burst(REF + thr);
      chk_pin(1'b0);
      burst(REF + thr - hy);
      chk_pin(1'b0);
      bus(1'b0, 4'h8, 32'h0);
      chk(got, {16'h0, REF});
      repeat (5) burst(REF + thr);
      chk_pin(i < 2);
      bus(1'b0, 4'h8, 32'h0);
      chk(got, {16'h0, (i == 3) ? REF : REF + thr});
      burst(REF);
      chk_pin(i != 2);
    end
    bus(1'b1, 4'h8, 32'h0000_FFFF);
    bus(1'b0, 4'h8, 32'h0);
    chk(got, {16'h0, REF});
    bus(1'b0, 4'h0, 32'h0);
    chk(got & 32'hFF, 32'h0000_00FF);
    bus(1'b0, 4'h2, 32'h0);
    chk(got, 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    chk(got, {16'h0, REF});
    bus(1'b0, 4'h4, 32'h0);
    chk(got, 32'h0000_2026);
    test_done();
  end
endmodule // tdo_touch_out_tb
